/* File: evp_pkg.sv */
package evp_pkg;
    // register byte addresses on the apb slave
    localparam logic [11:0] VBR_ADDR = 12'h000;
    localparam logic [11:0] CTRL_ADDR = 12'h004;
    localparam logic [11:0] STAT_ADDR = 12'h008;
    localparam logic [11:0] VEC_ADDR = 12'h00c;
    // reset values
    localparam logic [7:0] VBR_RESET = 8'hff;
    localparam logic [7:0] DEBUG_UPPER = 8'hff;
    // fixed reset vectors
    localparam logic [15:0] VEC_POR = 16'hfffe;
    localparam logic [15:0] VEC_CLKMON = 16'hfffc;
    localparam logic [15:0] VEC_WDOG = 16'hfffa;
    // offsets from the vector base
    localparam logic [7:0] OFS_TRAP = 8'hf8;
    localparam logic [7:0] OFS_SWI = 8'hf6;
    localparam logic [7:0] OFS_XMASK = 8'hf4;
    localparam logic [7:0] OFS_EXT = 8'hf2;
    localparam logic [7:0] OFS_PERI_TOP = 8'hf0;
    localparam logic [7:0] OFS_SPUR = 8'h80;
    // peripheral sources: index i sits at OFS_PERI_TOP - 2*i
    localparam int NUM_PERI = 56;
    // control register fields
    localparam int CTRL_IMASK = 0;
    localparam int CTRL_XMASK = 1;
    localparam int CTRL_DIELINK = 2;
    localparam int CTRL_DEBUG = 3;
    localparam logic [3:0] CTRL_RESET = 4'h3;
    typedef enum logic [2:0] {
        EVP_IDLE = 3'b001,
        EVP_ACCESS = 3'b010,
        EVP_DONE = 3'b100
    } evp_apb_state_t;
endpackage

/* File: evp_prio.sv */
`timescale 1ns/1ns
// combinational priority decoder from request vector to 16-bit address
module evp_prio
    import evp_pkg::*;
(
    input wire logic rst_por,
    input wire logic rst_clkmon,
    input wire logic rst_wdog,
    input wire logic trap,
    input wire logic software_interrupt_instruction,
    input wire logic xreq,
    input wire logic ext,
    input wire logic [evp_pkg::NUM_PERI-1:0] peri,
    input wire logic imask,
    input wire logic xmask,
    input wire logic [7:0] upper,
    output logic [15:0] vector,
    output logic hit
);
    logic [7:0] peri_ofs [0:evp_pkg::NUM_PERI];
    logic [evp_pkg::NUM_PERI:0] peri_any;
    logic [7:0] ofs;
    logic xq;
    logic iq;

    // walk from the highest index downward so the lowest index, at the highest vector, wins last
    assign peri_ofs[NUM_PERI] = OFS_SPUR;
    assign peri_any[NUM_PERI] = 1'b0;
    genvar i;
    generate
        for (i = NUM_PERI - 1; i >= 0; i--) begin : g_peri
            assign peri_any[i] = peri_any[i+1] | peri[i];
            assign peri_ofs[i] = peri[i] ? 8'(OFS_PERI_TOP - 8'(2 * i)) : peri_ofs[i+1];
        end
    endgenerate

    assign xq = xreq & ~xmask;
    assign iq = ~imask & (ext | peri_any[0]);
    // higher vector wins; non-maskable beats maskable
    assign ofs = trap ? OFS_TRAP : software_interrupt_instruction ? OFS_SWI : xq ? OFS_XMASK :
                 (iq & ext) ? OFS_EXT : iq ? peri_ofs[0] : OFS_SPUR;
    assign hit = trap | software_interrupt_instruction | xq | iq;
    // resets ignore the base register entirely
    assign vector = rst_por ? VEC_POR : rst_clkmon ? VEC_CLKMON : rst_wdog ? VEC_WDOG :
                    {upper, ofs};
endmodule

/* File: evp_top.sv */
`timescale 1ns/1ns
module evp_top
    import evp_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rst_por,
    input wire logic rst_clkmon,
    input wire logic rst_wdog,
    input wire logic trap_req,
    input wire logic swi_req,
    input wire logic xmask_pin_request,
    input wire logic ext_pin_request,
    input wire logic die_link_err_irq,
    input wire logic die_link_irq,
    input wire logic [evp_pkg::NUM_PERI-1:0] peri_req,
    input wire logic vec_req,
    output logic [15:0] vec_addr,
    output logic vec_valid,
    output logic vec_resume,
    output logic wake_async
);
    import evp_pkg::*;

    evp_apb_state_t state_q, state_d;
    logic [7:0] vbr_q;
    logic [3:0] ctrl_q;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_d, pslverr_q;
    logic [15:0] vec_q;
    logic vec_valid_q, vec_resume_q;
    logic [15:0] vector;
    logic hit;
    logic [7:0] upper;
    logic xsrc, esrc;
    logic any_reset;
    logic sel_vbr, sel_ctrl, sel_stat, sel_vec, mapped;
    logic wr_take;

    // die-link parts take the internal lines instead of the pins
    assign xsrc = ctrl_q[CTRL_DIELINK] ? die_link_err_irq : xmask_pin_request;
    assign esrc = ctrl_q[CTRL_DIELINK] ? die_link_irq : ext_pin_request;
    assign upper = ctrl_q[CTRL_DEBUG] ? DEBUG_UPPER : vbr_q;
    assign any_reset = rst_por | rst_clkmon | rst_wdog;

    // pure gates: the clock is stopped during stop mode, so nothing here may be sampled.
    // this output is the one top output not from a flop, by necessity.
    assign wake_async = xsrc | (~ctrl_q[CTRL_IMASK] & (esrc | (|peri_req)));

    evp_prio u_prio (
        .rst_por(rst_por),
        .rst_clkmon(rst_clkmon),
        .rst_wdog(rst_wdog),
        .trap(trap_req),
        .software_interrupt_instruction(swi_req),
        .xreq(xsrc),
        .ext(esrc),
        .peri(peri_req),
        .imask(ctrl_q[CTRL_IMASK]),
        .xmask(ctrl_q[CTRL_XMASK]),
        .upper(upper),
        .vector(vector),
        .hit(hit)
    );

    // vector latched only when the cpu asks, so a late higher request still wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            vec_q <= VEC_POR;
            vec_valid_q <= 1'b0;
            vec_resume_q <= 1'b0;
        end else if (clk_en) begin
            vec_valid_q <= vec_req;
            // masked x wake with nothing else pending: resume, no handler
            vec_resume_q <= vec_req & ~any_reset & ~hit & xsrc & ctrl_q[CTRL_XMASK];
            if (vec_req) begin
                vec_q <= vector;
            end
        end
    end

    // apb address decode
    assign sel_vbr = (paddr == VBR_ADDR);
    assign sel_ctrl = (paddr == CTRL_ADDR);
    assign sel_stat = (paddr == STAT_ADDR);
    assign sel_vec = (paddr == VEC_ADDR);
    assign mapped = sel_vbr | sel_ctrl | sel_stat | sel_vec;
    // writes land on the edge where pready is seen high, never earlier
    assign wr_take = (state_q == EVP_DONE) & psel & penable & pwrite & mapped;

    // one wait state: setup, access (pready low), done (pready high)
    always_comb begin
        state_d = state_q;
        case (state_q)
            EVP_IDLE: begin
                if (psel && !penable) begin
                    state_d = EVP_ACCESS;
                end
            end
            EVP_ACCESS: begin
                state_d = EVP_DONE;
            end
            EVP_DONE: begin
                state_d = EVP_IDLE;
            end
            default: begin
                state_d = EVP_IDLE;
            end
        endcase
    end

    // read mux; status shows live request and wake state
    always_comb begin
        prdata_d = 32'h0000_0000;
        pslverr_d = ~mapped;
        if (sel_vbr) begin
            prdata_d = {24'h00_0000, vbr_q};
        end else if (sel_ctrl) begin
            prdata_d = {28'h000_0000, ctrl_q};
        end else if (sel_stat) begin
            prdata_d = {26'h000_0000, wake_async, hit, esrc, xsrc, swi_req, trap_req};
        end else if (sel_vec) begin
            prdata_d = {16'h0000, vec_q};
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= EVP_IDLE;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            if (state_q == EVP_ACCESS) begin
                prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
                pslverr_q <= pslverr_d;
            end
        end
    end

    // register writes; a system reset restores the base before any reset vector is used
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            vbr_q <= VBR_RESET;
            ctrl_q <= CTRL_RESET;
        end else if (clk_en) begin
            if (any_reset) begin
                vbr_q <= VBR_RESET;
            end else if (wr_take && sel_vbr) begin
                vbr_q <= pwdata[7:0];
            end
            if (wr_take && sel_ctrl) begin
                ctrl_q <= pwdata[3:0];
            end
        end
    end

    assign pready = (state_q == EVP_DONE);
    assign prdata = prdata_q;
    assign pslverr = pslverr_q & pready;
    assign vec_addr = vec_q;
    assign vec_valid = vec_valid_q;
    assign vec_resume = vec_resume_q;
endmodule

/* File: evp_sva.sv */
`timescale 1ns/1ns
// watches vector and apb handshakes at the top ports
module evp_sva (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rst_por,
    input wire logic rst_clkmon,
    input wire logic rst_wdog,
    input wire logic xmask_pin_request,
    input wire logic vec_req,
    input wire logic [15:0] vec_addr,
    input wire logic vec_valid,
    input wire logic wake_async
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // a vector request or an apb setup taken at an edge
    sequence take_s; vec_req && clk_en; endsequence
    sequence setup_s; psel && !penable && clk_en; endsequence
    valid_follow_a: assert property (clk_en |=> vec_valid == $past(vec_req)) else $error("valid lag");
    por_vec_a: assert property (take_s ##0 rst_por |=> vec_addr == 16'hfffe) else $error("por vec");
    clkmon_vec_a: assert property (take_s ##0 (!rst_por && rst_clkmon) |=> vec_addr == 16'hfffc)
        else $error("clkmon vec");
    wdog_vec_a: assert property (take_s ##0 (!rst_por && !rst_clkmon && rst_wdog) |=> vec_addr == 16'hfffa)
        else $error("wdog vec");
    // wake must not wait for a clock, so it is checked in the same cycle
    xwake_a: assert property (xmask_pin_request |-> wake_async) else $error("x wake");
    vec_hold_a: assert property (clk_en && !vec_req |=> $stable(vec_addr)) else $error("vec moved");
    apb_wait_a: assert property (setup_s |-> ##2 pready) else $error("apb wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready long");
    err_ready_a: assert property (pslverr |-> pready) else $error("err alone");
endmodule

/* File: evp_cpu_model.sv */
`timescale 1ns/1ns
// cpu side: asks for a vector and takes it once the valid flag shows
module evp_cpu_model (
    input wire logic core_clk,
    input wire logic [15:0] vec_addr,
    input wire logic vec_valid,
    input wire logic vec_resume,
    output logic vec_req
);
    initial vec_req = 1'b0;
    // one-cycle request; a stale valid cannot be mistaken since we wait past the taking edge
    task automatic fetch(output logic [15:0] v, output logic rs);
        int n;
        n = 0;
        vec_req <= 1'b1;
        @(posedge core_clk);
        vec_req <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (vec_valid !== 1'b1 && n < 8);
        v = vec_addr;
        rs = vec_resume;
    endtask
endmodule

/* File: tb_evp_top.sv */
`timescale 1ns/1ns
module tb_evp_top;
    import evp_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [2:0] rsts = '0;
    logic [3:0] src = '0;
    logic [1:0] dl = '0;
    logic [NUM_PERI-1:0] peri = '0;
    logic [31:0] prdata, rd;
    logic [15:0] vec_addr, va;
    logic pready, pslverr, vec_req, vec_valid, vec_resume, wake_async, er, rs;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] ofs [7] = '{8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'h82, 8'h80};
    logic [15:0] rvec [4] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8};
    always #4 core_clk = ~core_clk;
    evp_top evp_top_i (
        .core_clk, .arst_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rst_por(rsts[2]), .rst_clkmon(rsts[1]), .rst_wdog(rsts[0]), .trap_req(src[3]),
        .swi_req(src[2]), .xmask_pin_request(src[1]), .ext_pin_request(src[0]), .die_link_err_irq(dl[1]),
        .die_link_irq(dl[0]), .peri_req(peri), .vec_req, .vec_addr, .vec_valid, .vec_resume, .wake_async
    );
    evp_cpu_model evp_cpu_model_i (.core_clk, .vec_addr, .vec_valid, .vec_resume, .vec_req);
    // apb transfer; the idle edge first keeps psel from being set twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic t_regs;
        apb(1'b0, VBR_ADDR, '0);
        chk("vbr", 16'h00ff, rd[15:0]);
        apb(1'b0, CTRL_ADDR, '0);
        chk("ctrl", 16'h0003, rd[15:0]);
        apb(1'b1, 12'h010, 32'h0000_0055);
        chk("unmapped", 16'h0001, 16'(er));
    endtask
    // trap, swi, x pin and ext pin plus the first and last peripheral up at once, then the winner is dropped step by step
    task automatic t_table;
        apb(1'b1, VBR_ADDR, 32'h0000_0040);
        apb(1'b1, CTRL_ADDR, '0);
        src <= 4'hf;
        peri[0] <= 1'b1;
        peri[NUM_PERI-1] <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            evp_cpu_model_i.fetch(va, rs);
            chk("vec", {8'h40, ofs[i]}, va);
            if (i < 4) src[3-i] <= 1'b0;
            else if (i == 4) peri[0] <= 1'b0;
            else peri[NUM_PERI-1] <= 1'b0;
        end
    endtask
    task automatic t_mask;
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        peri[3] <= 1'b1;
        evp_cpu_model_i.fetch(va, rs);
        chk("imask vec", 16'h4080, va);
        chk("imask wake", 16'h0000, 16'(wake_async));
        apb(1'b1, CTRL_ADDR, '0);
        evp_cpu_model_i.fetch(va, rs);
        chk("iopen vec", 16'h40ea, va);
        chk("iopen wake", 16'h0001, 16'(wake_async));
        peri[3] <= 1'b0;
    endtask
    task automatic t_xwake;
        apb(1'b1, CTRL_ADDR, 32'h0000_0002);
        src[1] <= 1'b1;
        evp_cpu_model_i.fetch(va, rs);
        chk("x wake", 16'h0001, 16'(wake_async));
        chk("resume", 16'h0001, 16'(rs));
        chk("x vec", 16'h4080, va);
        src[1] <= 1'b0;
    endtask
    task automatic t_debug;
        apb(1'b1, CTRL_ADDR, 32'h0000_000b);
        src[2] <= 1'b1;
        evp_cpu_model_i.fetch(va, rs);
        chk("debug vec", 16'hfff6, va);
        src[2] <= 1'b0;
        apb(1'b1, CTRL_ADDR, '0);
    endtask
    // die-link select: internal lines replace the pins, last vector read back over apb
    task automatic t_dielink;
        apb(1'b1, CTRL_ADDR, 32'h0000_0004);
        dl <= 2'b11;
        evp_cpu_model_i.fetch(va, rs);
        chk("dl err vec", 16'h40f4, va);
        dl <= 2'b01;
        evp_cpu_model_i.fetch(va, rs);
        chk("dl irq vec", 16'h40f2, va);
        apb(1'b0, VEC_ADDR, '0);
        chk("last vec", 16'h40f2, rd[15:0]);
        dl <= 2'b00;
        apb(1'b1, CTRL_ADDR, '0);
    endtask
    // reset vectors in falling rank; the last trap shows the base went back to ff
    task automatic t_resets;
        src[3] <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rsts <= 3'b111 >> i;
            evp_cpu_model_i.fetch(va, rs);
            chk("reset vec", rvec[i], va);
        end
        src[3] <= 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            close_out;
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        t_regs;
        t_table;
        t_mask;
        t_xwake;
        t_debug;
        t_dielink;
        t_resets;
        close_out;
    end
endmodule
bind evp_top evp_sva evp_sva_i (.core_clk, .arst_n, .clk_en, .psel, .penable, .pready, .pslverr, .rst_por,
    .rst_clkmon, .rst_wdog, .xmask_pin_request, .vec_req, .vec_addr, .vec_valid, .wake_async);
